// ===== logic/iomd_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the diagnostic record
// Assumes: One 40 MHz module clock
// Notes:   Definitions only; included by bare name
`ifndef IOMD_PARAMS_SVH
`define IOMD_PARAMS_SVH

// Record set numbers
`define IOMD_SET_SHORT      8'h00
`define IOMD_SET_FULL       8'h01
// Bytes visible per record set
`define IOMD_SHORT_LEN      5'h04
`define IOMD_FULL_LEN       5'h14

// Byte positions inside the record
`define IOMD_IDX_MOD_ERR    0
`define IOMD_IDX_MOD_CLASS  1
`define IOMD_IDX_RSVD       2
`define IOMD_IDX_COMM_ERR   3
`define IOMD_IDX_CH_KIND    4
`define IOMD_IDX_DIAG_BITS  5
`define IOMD_IDX_CH_COUNT   6
`define IOMD_IDX_CH_SUM     7
`define IOMD_IDX_CH_FLAGS0  8
`define IOMD_IDX_STAMP0     16

// Module error byte fields
`define IOMD_MOD_FAIL_BIT   0
`define IOMD_MOD_INT_BIT    1
`define IOMD_MOD_EXT_BIT    2
`define IOMD_MOD_CHAN_BIT   3
`define IOMD_MOD_AUX_BIT    4
`define IOMD_MOD_PARAM_BIT  7
// Communication error byte field
`define IOMD_COMM_BIT       4
// Channel error byte fields
`define IOMD_CH_PARAM_BIT   0
`define IOMD_CH_UNDER_BIT   6
`define IOMD_CH_OVER_BIT    7

// Fixed descriptor values
`define IOMD_CLASS_ANALOG   4'h5
`define IOMD_CLASS_INFO     8'h15
`define IOMD_KIND_AIN       8'h71
`define IOMD_DIAG_BITS      8'h08
`define IOMD_CH_COUNT       8'h08
`define IOMD_BYTE_ZERO      8'h00

// Ticker timing
`define IOMD_CLK_PERIOD_NS  25
`define IOMD_TICK_NS        1000
`define IOMD_TICK_CYCLES    (`IOMD_TICK_NS / `IOMD_CLK_PERIOD_NS)

`endif

// ===== logic/iomd_pkg.sv
// Purpose: Types shared by the diagnostic record files
// Assumes: Constants live in iomd_params.svh
// Notes:   Condition inputs travel as packed structs
package iomd_pkg;

    // Module level error conditions
    typedef struct packed {
        logic failure;      // Module failure
        logic internal;     // Internal error
        logic external;     // External error
        logic aux_missing;  // Auxiliary supply missing
        logic param_err;    // Parameterization error
        logic comm_err;     // Internal communication error
    } iomd_mod_cond_s;

    // Per channel error conditions
    typedef struct packed {
        logic param_err;    // Configuration error
        logic underflow;    // Below measuring range
        logic overflow;     // Above measuring range
    } iomd_ch_cond_s;

    // Read answer kind
    typedef enum logic [1:0] {
        IOMD_ANS_NONE,
        IOMD_ANS_DATA,
        IOMD_ANS_REFUSED
    } iomd_ans_e;

endpackage : iomd_pkg

// ===== logic/iomd_us_ticker.sv
// Purpose: Free running 32-bit microsecond ticker
// Assumes: 40 MHz clock, one enable pulse per microsecond
// Notes:   Wraps to zero after the maximum count
`timescale 1ns/100ps
`include "iomd_params.svh"

module iomd_us_ticker
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    // Ticker state
    output logic [31:0]      ticks_o,
    output logic             tick_o
);

    localparam logic [5:0] DIV_LAST = 6'(`IOMD_TICK_CYCLES - 1);

    logic [5:0]  div_cnt;       // Cycles inside one microsecond
    logic        div_wrap;      // Last cycle of the microsecond
    logic [5:0]  next_div_cnt;
    logic [31:0] next_ticks;

    assign div_wrap     = (div_cnt == DIV_LAST);
    assign next_div_cnt = div_wrap ? 6'h00 : div_cnt + 6'h01;
    // Natural 32-bit rollover restarts from zero
    assign next_ticks   = ticks_o + 32'h0000_0001;

    // Divider and counter start straight from reset release
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            div_cnt <= 6'h00;
            ticks_o <= 32'h0000_0000;
            tick_o  <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            tick_o  <= div_wrap;
            if (div_wrap)
            begin
                ticks_o <= next_ticks;
            end
        end
    end

    // Count moves by one exactly once per microsecond
    tick_step_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        tick_o |-> (ticks_o == $past(ticks_o) + 32'h0000_0001) ##1 !tick_o [*8])
        else $error("ticker step wrong");

    // Wrap from the top back to zero
    tick_wrap_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (tick_o && $past(ticks_o) == 32'hFFFF_FFFF) |-> (ticks_o == 32'h0000_0000))
        else $error("ticker did not wrap");

    // Pulses spaced by the full microsecond
    tick_space_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        $rose(tick_o) |=> !tick_o [*8] ##[32:32] tick_o)
        else $error("ticker spacing wrong");

endmodule : iomd_us_ticker

// ===== logic/iomd_diag_record.sv
// Purpose: Diagnostic record of an eight channel analog input module
// Assumes: Condition inputs come from pins or other domains; read port is on mclk_i
// Notes:   Record follows the conditions; no write path exists
`timescale 1ns/100ps
`include "iomd_params.svh"

module iomd_diag_record
(
    // Clock and reset
    input  wire logic                          mclk_i,
    input  wire logic                          reset_n_i,
    // Error conditions from the module
    input  wire iomd_pkg::iomd_mod_cond_s      mod_cond_i,
    input  wire iomd_pkg::iomd_ch_cond_s [7:0] ch_cond_i,
    // Record read request from the coupler side
    input  wire logic                          rd_req_i,
    input  wire logic [7:0]                    rd_set_i,
    input  wire logic [4:0]                    rd_index_i,
    // Record read answer
    output logic                               rd_valid_o,
    output logic                               rd_refused_o,
    output logic [7:0]                         rd_data_o,
    // Indicators
    output logic [7:0]                         ch_led_o,
    output logic                               mod_led_o
);

    // Synchroniser stages for the condition pins
    iomd_pkg::iomd_mod_cond_s      mod_meta;    // First stage, read only by second
    iomd_pkg::iomd_mod_cond_s      mod_sync;    // Safe module conditions
    iomd_pkg::iomd_ch_cond_s [7:0] ch_meta;     // First stage, read only by second
    iomd_pkg::iomd_ch_cond_s [7:0] ch_sync;     // Safe channel conditions

    // Record contents held in flops
    logic [7:0]  mod_err;                       // Module error byte
    logic [7:0]  comm_err;                      // Communication error byte
    logic [7:0]  ch_flags [0:7];                // Per channel error bytes
    logic [31:0] stamp;                         // Ticker value at last event

    // Next values of the record
    logic [7:0]  next_mod_err;
    logic [7:0]  next_comm_err;
    logic [7:0]  next_ch_flags [0:7];
    logic [7:0]  next_summary;
    logic [7:0]  summary;                       // Per channel error summary

    // Event detection and ticker
    logic        diag_event;                    // Some flag about to rise
    logic [31:0] ticks;                         // Current microsecond count
    logic [31:0] event_rise;                    // Rising flags of module, comm and summary bytes

    // Read decode
    logic [7:0]  rec_byte [0:19];               // Record as bytes
    logic        set_short;
    logic        set_full;
    logic        idx_ok;
    logic [7:0]  sel_byte;
    iomd_pkg::iomd_ans_e ans_kind;

    // Microsecond ticker, running from reset release
    iomd_us_ticker u_ticker
    (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .ticks_o   (ticks),
        .tick_o    ()
    );

    // Two flops on every condition pin before any logic looks at it
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mod_meta <= '0;
            mod_sync <= '0;
            ch_meta  <= '0;
            ch_sync  <= '0;
        end
        else
        begin
            mod_meta <= mod_cond_i;
            mod_sync <= mod_meta;
            ch_meta  <= ch_cond_i;
            ch_sync  <= ch_meta;
        end
    end

    // Per channel byte and summary bit, one copy per channel
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++)
        begin : g_chan
            // Reserved bits 5..1 stay zero
            assign next_ch_flags[ch] = {ch_sync[ch].overflow,
                                        ch_sync[ch].underflow,
                                        5'h00,
                                        ch_sync[ch].param_err};
            // Any flag in the channel byte marks the channel
            assign next_summary[ch]  = |next_ch_flags[ch];
            assign summary[ch]       = |ch_flags[ch];
            assign rec_byte[`IOMD_IDX_CH_FLAGS0 + ch] = ch_flags[ch];
        end
    endgenerate

    // Module error byte, bits 6..5 reserved
    assign next_mod_err = {mod_sync.param_err,
                           2'h0,
                           mod_sync.aux_missing,
                           |next_summary,
                           mod_sync.external,
                           mod_sync.internal,
                           mod_sync.failure};
    // Communication byte, only bit 4 is live
    assign next_comm_err = {3'h0, mod_sync.comm_err, 4'h0};

    // A diagnostic event is any module, communication or summary flag going from clear to set
    assign event_rise = {next_mod_err & ~mod_err,
                         next_comm_err & ~comm_err,
                         next_summary & ~summary,
                         8'h00};
    assign diag_event = |event_rise;

    // Record follows the conditions each cycle, so a flag drops once
    // its cause is gone; this trades history for an always current view
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mod_err  <= `IOMD_BYTE_ZERO;
            comm_err <= `IOMD_BYTE_ZERO;
        end
        else
        begin
            mod_err  <= next_mod_err;
            comm_err <= next_comm_err;
        end
    end

    // Channel bytes, same update policy
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                ch_flags[i] <= `IOMD_BYTE_ZERO;
            end
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                ch_flags[i] <= next_ch_flags[i];
            end
        end
    end

    // Timestamp taken in the cycle the record gains a module, communication or summary flag
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            stamp <= 32'h0000_0000;
        end
        else if (diag_event)
        begin
            stamp <= ticks;
        end
    end

    // Channel indicators mirror the summary byte, module indicator the module byte less bit 3; lit with the flag
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ch_led_o  <= 8'h00;
            mod_led_o <= 1'b0;
        end
        else
        begin
            ch_led_o  <= next_summary;
            mod_led_o <= |(next_mod_err & 8'h97);
        end
    end

    // Record laid out as bytes; fixed descriptors are constants
    assign rec_byte[`IOMD_IDX_MOD_ERR]   = mod_err;
    assign rec_byte[`IOMD_IDX_MOD_CLASS] = `IOMD_CLASS_INFO;
    assign rec_byte[`IOMD_IDX_RSVD]      = `IOMD_BYTE_ZERO;
    assign rec_byte[`IOMD_IDX_COMM_ERR]  = comm_err;
    assign rec_byte[`IOMD_IDX_CH_KIND]   = `IOMD_KIND_AIN;
    assign rec_byte[`IOMD_IDX_DIAG_BITS] = `IOMD_DIAG_BITS;
    assign rec_byte[`IOMD_IDX_CH_COUNT]  = `IOMD_CH_COUNT;
    assign rec_byte[`IOMD_IDX_CH_SUM]    = summary;
    // Timestamp, low byte first
    assign rec_byte[`IOMD_IDX_STAMP0]     = stamp[7:0];
    assign rec_byte[`IOMD_IDX_STAMP0 + 1] = stamp[15:8];
    assign rec_byte[`IOMD_IDX_STAMP0 + 2] = stamp[23:16];
    assign rec_byte[`IOMD_IDX_STAMP0 + 3] = stamp[31:24];

    // Record set decode: short set sees only the first four bytes
    assign set_short = (rd_set_i == `IOMD_SET_SHORT);
    assign set_full  = (rd_set_i == `IOMD_SET_FULL);
    assign idx_ok    = (set_short && rd_index_i < `IOMD_SHORT_LEN)
                    || (set_full && rd_index_i < `IOMD_FULL_LEN);
    assign sel_byte  = idx_ok ? rec_byte[rd_index_i] : `IOMD_BYTE_ZERO;
    assign ans_kind  = !rd_req_i ? iomd_pkg::IOMD_ANS_NONE
                     : idx_ok    ? iomd_pkg::IOMD_ANS_DATA
                     :             iomd_pkg::IOMD_ANS_REFUSED;

    // Answer one cycle after the request; there is no write port at all
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rd_valid_o   <= 1'b0;
            rd_refused_o <= 1'b0;
            rd_data_o    <= 8'h00;
        end
        else
        begin
            case (ans_kind)
                iomd_pkg::IOMD_ANS_DATA:
                begin
                    rd_valid_o   <= 1'b1;
                    rd_refused_o <= 1'b0;
                    rd_data_o    <= sel_byte;
                end
                iomd_pkg::IOMD_ANS_REFUSED:
                begin
                    rd_valid_o   <= 1'b0;
                    rd_refused_o <= 1'b1;
                    rd_data_o    <= 8'h00;
                end
                default:
                begin
                    rd_valid_o   <= 1'b0;
                    rd_refused_o <= 1'b0;
                    rd_data_o    <= rd_data_o;
                end
            endcase
        end
    end

    // Helper: cycles since reset release, so $past reaches valid history
    logic [1:0] warm;
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            warm <= 2'h0;
        end
        else if (warm != 2'h3)
        begin
            warm <= warm + 2'h1;
        end
    end

    // Module flags follow pins three edges later
    mod_flags_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (warm == 2'h3) |-> (mod_err[2:0] == {$past(mod_cond_i.external, 3),
                                             $past(mod_cond_i.internal, 3),
                                             $past(mod_cond_i.failure, 3)}))
        else $error("module error bits 2..0 wrong");

    // Channel flag agrees with the summary byte
    chan_flag_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        mod_err[3] == (summary != 8'h00))
        else $error("channel flag disagrees with summary");

    // Aux supply bit and parameter bit with reserved zeros
    aux_param_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (warm == 2'h3) |-> (mod_err[7] == $past(mod_cond_i.param_err, 3))
                        && (mod_err[4] == $past(mod_cond_i.aux_missing, 3))
                        && (mod_err[6:5] == 2'h0))
        else $error("module error bits 7..4 wrong");

    // Communication byte carries only bit 4
    comm_flag_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (warm == 2'h3) |-> (comm_err == {3'h0, $past(mod_cond_i.comm_err, 3), 4'h0}))
        else $error("communication byte wrong");

    // Range flags of channel 0 track its pins
    range_flags_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (warm == 2'h3) |-> (ch_flags[0] == {$past(ch_cond_i[0].overflow, 3),
                                            $past(ch_cond_i[0].underflow, 3),
                                            5'h00,
                                            $past(ch_cond_i[0].param_err, 3)}))
        else $error("channel 0 byte wrong");

    // Indicator lit together with the summary bit
    chan_led_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        ch_led_o == summary)
        else $error("channel indicator out of step");

    // Timestamp holds the ticker of the event cycle
    stamp_take_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        diag_event |=> (stamp == $past(ticks)))
        else $error("timestamp not captured");

    // Short set refuses bytes past the fourth
    short_set_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (rd_req_i && rd_set_i == 8'h00 && rd_index_i >= 5'h04)
            |=> (rd_refused_o && !rd_valid_o))
        else $error("short record set not refused");

    // Fixed descriptor answered on the full set
    descr_read_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (rd_req_i && rd_set_i == 8'h01 && rd_index_i == 5'h05)
            |=> (rd_valid_o && rd_data_o == 8'h08))
        else $error("diagnostic bit count wrong");

    // Unknown record sets get a refusal with a zero byte
    set_refuse_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (rd_req_i && rd_set_i > 8'h01)
            |=> (rd_refused_o && !rd_valid_o && rd_data_o == 8'h00))
        else $error("unknown record set not refused");

    // Timestamp only moves on a diagnostic event
    stamp_hold_a : assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !diag_event |=> $stable(stamp))
        else $error("timestamp moved without event");

endmodule : iomd_diag_record

// ===== tb/iomd_host_model.sv
// Purpose: Host side reader of the diagnostic record, one byte per request
// Assumes: Answer stands for one cycle, from the edge that takes the request
// Notes:   Released set and index lines show the inverse of the last value
`timescale 1ns/100ps

module iomd_host_model
(
    // Clock
    input  wire logic       mclk_i,
    // Read request
    output logic            rd_req_o,
    output logic [7:0]      rd_set_o,
    output logic [4:0]      rd_index_o,
    // Read answer
    input  wire logic       rd_valid_i,
    input  wire logic       rd_refused_i,
    input  wire logic [7:0] rd_data_i
);
    // Idle lines at time zero
    initial
    begin
        rd_req_o   = 1'b0;
        rd_set_o   = 8'h00;
        rd_index_o = 5'h00;
    end

    // One byte read by record set and index
    task automatic read_byte(input logic [7:0] set, input logic [4:0] idx,
                             output logic [7:0] data, output logic ok, output logic bad);
        @(posedge mclk_i);
        rd_req_o   <= 1'b1;
        rd_set_o   <= set;
        rd_index_o <= idx;
        @(posedge mclk_i);
        // Stale lines would hide a design that samples late
        rd_req_o   <= 1'b0;
        rd_set_o   <= ~set;
        rd_index_o <= ~idx;
        // Answer is a one-cycle pulse, so look mid-cycle
        @(negedge mclk_i);
        data = rd_data_i;
        ok   = rd_valid_i;
        bad  = rd_refused_i;
    endtask : read_byte
endmodule : iomd_host_model

// ===== tb/test_io_module_diagnostic_record.sv
// Purpose: Self-checking bench of the diagnostic record
// Assumes: Conditions reach the record within 3 edges; ticker steps every 40 cycles
// Notes:   Ticker wrap needs 2^32 us and is left to the design's own assertion
`timescale 1ns/100ps

module test_io_module_diagnostic_record;
    // Clock, reset and stimulus
    logic                        mclk_i;
    logic                        reset_n_i;
    iomd_pkg::iomd_mod_cond_s    mod_cond;
    iomd_pkg::iomd_ch_cond_s [7:0] ch_cond;
    // Read port wires
    logic                        rd_req;
    logic [7:0]                  rd_set;
    logic [4:0]                  rd_index;
    logic                        rd_valid;
    logic                        rd_refused;
    logic [7:0]                  rd_data;
    // Indicators
    logic [7:0]                  ch_led;
    logic                        mod_led;
    // Bookkeeping
    int                          err_count;
    int                          checks;
    int                          cyc;
    logic [31:0]                 stamp;

    iomd_diag_record uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .mod_cond_i(mod_cond),
        .ch_cond_i(ch_cond), .rd_req_i(rd_req), .rd_set_i(rd_set), .rd_index_i(rd_index),
        .rd_valid_o(rd_valid), .rd_refused_o(rd_refused), .rd_data_o(rd_data),
        .ch_led_o(ch_led), .mod_led_o(mod_led));

    iomd_host_model host (.mclk_i(mclk_i), .rd_req_o(rd_req), .rd_set_o(rd_set),
        .rd_index_o(rd_index), .rd_valid_i(rd_valid), .rd_refused_i(rd_refused),
        .rd_data_i(rd_data));

    // 40 MHz clock
    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // Cycles since reset release, for ticker expectations
    always @(posedge mclk_i or negedge reset_n_i)
        if (!reset_n_i) cyc <= 0;
        else cyc <= cyc + 1;

    // Channel error summary from the conditions
    function automatic logic [7:0] sum_f();
        for (int n = 0; n < 8; n++)
            sum_f[n] = |ch_cond[n];
    endfunction : sum_f

    // Expected record byte from the current conditions
    function automatic logic [7:0] exp_byte(input int idx);
        case (idx)
            0: exp_byte = {mod_cond.param_err, 2'h0, mod_cond.aux_missing, |sum_f(),
                           mod_cond.external, mod_cond.internal, mod_cond.failure};
            1: exp_byte = 8'h15;
            3: exp_byte = {3'h0, mod_cond.comm_err, 4'h0};
            4: exp_byte = 8'h71;
            5, 6: exp_byte = 8'h08;
            7: exp_byte = sum_f();
            8, 9, 10, 11, 12, 13, 14, 15:
                exp_byte = {ch_cond[idx-8].overflow, ch_cond[idx-8].underflow, 5'h00,
                            ch_cond[idx-8].param_err};
            default: exp_byte = 8'h00;
        endcase
    endfunction : exp_byte

    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // Read one byte and compare data and answer kind
    task automatic rd(input logic [7:0] set, input int idx, input logic refused);
        logic [7:0] d;
        logic       ok;
        logic       bad;
        host.read_byte(set, 5'(idx), d, ok, bad);
        check(d, refused ? 8'h00 : exp_byte(idx), "record byte");
        check({6'h00, ok, bad}, {6'h00, !refused, refused}, "answer kind");
    endtask : rd

    // Read the four stamp bytes, low byte first
    task automatic rd_stamp();
        logic ok;
        logic bad;
        for (int b = 0; b < 4; b++)
        begin
            host.read_byte(8'h01, 5'(16 + b), stamp[8*b +: 8], ok, bad);
            check({6'h00, ok, bad}, 8'h02, "stamp answer");
        end
    endtask : rd_stamp

    // Verdict
    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // Hang guard
    initial
    begin
        repeat (60000) @(posedge mclk_i);
        err_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        results();
    end

    // Main sequence
    initial
    begin
        int c;
        reset_n_i = 1'b0;
        mod_cond  = '0;
        ch_cond   = '0;
        err_count = 0;
        checks    = 0;
        void'($urandom(32'ha9f7_0bc8));
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        // Descriptors, reserved byte, both record sets
        for (int i = 0; i < 8; i++) rd(8'h01, i, 1'b0);
        for (int i = 0; i < 4; i++) rd(8'h00, i, 1'b0);
        // Out of range indices and unknown sets
        rd(8'h00, 4, 1'b1);
        rd(8'h01, 20, 1'b1);
        rd(8'h02 + 8'($urandom_range(253)), 0, 1'b1);
        $display("test descriptors done");
        // Random conditions, first all set, then all clear
        for (int k = 0; k < 24; k++)
        begin
            @(posedge mclk_i);
            mod_cond <= (k == 0) ? 6'h3f : (k == 1) ? 6'h00 : 6'($urandom);
            ch_cond  <= (k == 0) ? 24'hff_ffff : (k == 1) ? 24'h00_0000 : 24'($urandom);
            repeat (5) @(posedge mclk_i);
            for (int i = 0; i < 16; i++) rd(8'h01, i, 1'b0);
            rd(8'h00, 0, 1'b0);
            check(ch_led, sum_f(), "channel leds");
            check({7'h00, mod_led}, {7'h00, mod_cond.failure | mod_cond.internal |
                  mod_cond.external | mod_cond.aux_missing | mod_cond.param_err}, "module led");
        end
        $display("test conditions done");
        // Stamp of two events just over 25 us apart
        @(posedge mclk_i);
        mod_cond <= '0;
        ch_cond  <= '0;
        for (int e = 0; e < 2; e++)
        begin
            repeat (1000) @(posedge mclk_i);
            c = cyc;
            ch_cond[e].overflow <= 1'b1;
            repeat (5) @(posedge mclk_i);
            rd_stamp();
            checks++;
            if (stamp < 32'(c / 40) || stamp > 32'((c + 5) / 40))
            begin
                err_count++;
                $display("MISMATCH t=%0t stamp %0d cycle %0d", $time, stamp, c);
            end
        end
        $display("test timestamp done");
        // Second reset with conditions standing
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(negedge mclk_i);
        check(ch_led, 8'h00, "leds in reset");
        check({7'h00, mod_led}, 8'h00, "module led in reset");
        @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        rd(8'h01, 7, 1'b0);
        $display("test second reset done");
        results();
    end
endmodule : test_io_module_diagnostic_record
